// ### design/i2c_margin_watchdog_cfg.svh
/*
 * Constants of the margining and supervisor-timer command block.
 * Assumes a 250 MHz core clock and a 7-bit bus address.
 */
`ifndef I2C_MARGIN_WATCHDOG_CFG_SVH
`define I2C_MARGIN_WATCHDOG_CFG_SVH

// =====================================================================
// Bus address
`define SLAVE_ADDR_FIXED 5'h1d
`define BIT_LAST         3'h7

// =====================================================================
// Command byte fields
`define OP_POS           5
`define OP_MARGIN        3'h1
`define OP_WATCHDOG      3'h3
`define VAL_FIRST        5'h00
`define TARGET_POS       4
`define MARGIN_BAD       4'hf
`define WD_CODE_HI       2'h1
`define WD_WIN_POS       2

// =====================================================================
// Reset values
`define MARGIN_RESET     4'h0
`define WD_SEL_RESET     2'h0

// =====================================================================
// Timing: core clock in kHz equals cycles per millisecond
`define CLK_FREQ_KHZ     250000
`define WD_MS_SEL0       1280
`define WD_MS_SEL1       320
`define WD_MS_SEL2       80
`define WD_MS_SEL3       20

`endif

// ### design/i2c_margin_watchdog_pkg.sv
/*
 * Types shared by the byte receiver and the command interpreter.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package i2c_margin_watchdog_pkg;

	// =================================================================
	// Command interpreter states.
	typedef enum logic [2:0] {
		CMD_IDLE     = 3'b001,
		CMD_MARGIN   = 3'b010,
		CMD_WATCHDOG = 3'b100
	} cmd_state_t;

	// =================================================================
	// Bus receiver states.
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_ADDR = 5'b00010,
		RX_DATA = 5'b00100,
		RX_ACK  = 5'b01000,
		RX_SKIP = 5'b10000
	} rx_state_t;

endpackage

// ### design/rx_byte_if.sv
/*
 * Carrier of received command bytes from the bus receiver.
 * Assumes both ends sit on the same core clock.
 */
interface rx_byte_if;

	// =================================================================
	// Byte strobe, byte and end-of-transfer strobe.
	logic       byte_valid;
	logic [7:0] cmd_byte;
	logic       stop_seen;

	modport src (output byte_valid, output cmd_byte, output stop_seen);
	modport snk (input byte_valid, input cmd_byte, input stop_seen);

endinterface

// ### design/i2c_byte_rx.sv
/*
 * Write-only bus slave receiver: finds START and STOP, matches the
 * address, acknowledges and hands each data byte on.
 * Assumes bus pins already synchronous to the core clock.
 */
module i2c_byte_rx
	import i2c_margin_watchdog_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	// Bus pins and address straps
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic [1:0] addr_low_i,
	output logic            sda_oe_o,
	// Byte output
	rx_byte_if.src          link
);
`include "i2c_margin_watchdog_cfg.svh"

	rx_state_t  state,   next_state;
	logic [2:0] bit_cnt, next_cnt;
	logic [7:0] shreg,   next_sh;
	logic       scl_q,   sda_q;
	logic       next_oe, next_valid, next_stop;
	logic [7:0] next_data;
	logic [7:0] full;
	logic       scl_rise, scl_fall, start_c, stop_c;

	// =================================================================
	// Bus conditions seen from the previous pin samples.
	assign scl_rise = scl_i && !scl_q;
	assign scl_fall = !scl_i && scl_q;
	assign start_c  = scl_i && scl_q && sda_q && !sda_i;
	assign stop_c   = scl_i && scl_q && !sda_q && sda_i;
	assign full     = {shreg[6:0], sda_i};

	// Next state of the receiver.
	always_comb begin
		next_state = state;
		next_cnt   = bit_cnt;
		next_sh    = shreg;
		next_oe    = sda_oe_o;
		next_valid = 1'b0;
		next_stop  = 1'b0;
		next_data  = link.cmd_byte;
		if (start_c) begin
			next_state = RX_ADDR;
			next_cnt   = 3'h0;
			next_oe    = 1'b0;
		end else if (stop_c) begin
			next_state = RX_IDLE;
			next_oe    = 1'b0;
			next_stop  = (state != RX_IDLE);
		end else begin
			case (state)
				RX_ADDR: if (scl_rise) begin
					next_sh  = full;
					next_cnt = 3'(bit_cnt + 3'h1);
					if (bit_cnt == `BIT_LAST) begin
						// Only our address with a write bit is answered.
						if (full[7:1] == {`SLAVE_ADDR_FIXED, addr_low_i}
						    && !full[0])
							next_state = RX_ACK;
						else
							next_state = RX_SKIP;
					end
				end
				RX_DATA: if (scl_rise) begin
					next_sh  = full;
					next_cnt = 3'(bit_cnt + 3'h1);
					if (bit_cnt == `BIT_LAST) begin
						next_state = RX_ACK;
						next_valid = 1'b1;
						next_data  = full;
					end
				end
				RX_ACK: if (scl_fall) begin
					// Pull low for one whole clock pulse, then release.
					if (!sda_oe_o)
						next_oe = 1'b1;
					else begin
						next_oe    = 1'b0;
						next_state = RX_DATA;
					end
				end
				RX_IDLE, RX_SKIP: ;
				default: next_state = RX_IDLE;
			endcase
		end
	end

	// Receiver registers.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state           <= RX_IDLE;
			bit_cnt         <= 3'h0;
			shreg           <= 8'h00;
			scl_q           <= 1'b1;
			sda_q           <= 1'b1;
			sda_oe_o        <= 1'b0;
			link.byte_valid <= 1'b0;
			link.stop_seen  <= 1'b0;
			link.cmd_byte   <= 8'h00;
		end else begin
			state           <= next_state;
			bit_cnt         <= next_cnt;
			shreg           <= next_sh;
			scl_q           <= scl_i;
			sda_q           <= sda_i;
			sda_oe_o        <= next_oe;
			link.byte_valid <= next_valid;
			link.stop_seen  <= next_stop;
			link.cmd_byte   <= next_data;
		end
	end

	// =================================================================
	// Checks.
	a_read_refused: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		state == RX_ADDR && scl_rise && !start_c && !stop_c
		&& bit_cnt == `BIT_LAST && sda_i |=> state == RX_SKIP)
		else $error("Read address was not refused.");
	a_ack_only_in_ack: assert property (@(posedge core_clk_i)
		disable iff (!rst_b_i)
		sda_oe_o |-> state == RX_ACK)
		else $error("Data line driven outside an acknowledge.");

endmodule

// ### design/i2c_margin_watchdog_cmd.sv
/*
 * Command interpreter for output margining and the supervisor timer,
 * fed by a write-only bus slave.
 * Assumes bus pins synchronous to core_clk_i and an external pull-up.
 */
// Overview of operation
// - Only write transfers accepted, read refused.
// - Acknowledge own address and every data byte.
// - Several command bytes per transfer, each interpreted.
// - Byte splits into 3-bit operation, 5-bit value.
// - Operation 001 margins, 011 programs timer.
// - Each operation needs its preceding first command.
// - Value bit 4 selects linear or switcher.
// - Low four bits: nominal, plus or minus steps.
// - Two margin bytes after one first command; code takes any number until STOP or a timer first command.
// - Value 01wpp: window flag and period select.
// - Valid timer byte after first command starts timer.
// - Refresh in open window clears and reloads.
// - Timer first command twice stops timer.
// - STOP returns device to idle.
// - Address is fixed part plus two straps.
`include "i2c_margin_watchdog_cfg.svh"
module i2c_margin_watchdog_cmd
	import i2c_margin_watchdog_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = `CLK_FREQ_KHZ
)
(
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	// Bus pins
	input  wire logic scl_i,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe_o,
	// Address straps
	input  wire logic upper_select_bit_i,
	input  wire logic lower_select_bit_i,
	// Margining settings
	output logic [3:0] ldo_margin_o,
	output logic [3:0] switcher_margin_o,
	// Supervisor timer
	output logic       supervisor_timer_on_o,
	output logic       supervisor_window_mode_o,
	output logic [1:0] supervisor_period_sel_o,
	output logic       supervisor_window_open_o,
	output logic       supervisor_expired_o
);

	rx_byte_if  link ();
	cmd_state_t state, next_state;
	logic [1:0] addr_low;
	logic       strap_taken;
	logic [3:0] next_ldo, next_sw;
	logic       next_on, next_win, next_open, next_exp;
	logic [1:0] next_sel;
	logic [31:0] wd_cnt, next_cnt;
	logic [2:0] op;
	logic [4:0] val;
	logic       first_m, first_w;

	// Period length in core cycles for a period select code.
	function automatic logic [31:0] period_of(input logic [1:0] sel);
		logic [31:0] ms;
		case (sel)
			2'h0:    ms = 32'(`WD_MS_SEL0);
			2'h1:    ms = 32'(`WD_MS_SEL1);
			2'h2:    ms = 32'(`WD_MS_SEL2);
			default: ms = 32'(`WD_MS_SEL3);
		endcase
		return 32'(ms * CYCLES_PER_MS);
	endfunction

	// =================================================================
	// Straps are caught once, on the first edge after reset release.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			addr_low    <= 2'h0;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			addr_low    <= {upper_select_bit_i, lower_select_bit_i};
			strap_taken <= 1'b1;
		end
	end

	// The line is only ever pulled low, so the driven level stays zero.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			sda_o <= 1'b0;
		else
			sda_o <= 1'b0;
	end

	i2c_byte_rx u_rx (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.scl_i      (scl_i),
		.sda_i      (sda_i),
		.addr_low_i (addr_low),
		.sda_oe_o   (sda_oe_o),
		.link       (link.src)
	);

	// =================================================================
	// Command byte fields and first command patterns.
	assign op      = link.cmd_byte[7:`OP_POS];
	assign val     = link.cmd_byte[`OP_POS-1:0];
	assign first_m = op == `OP_MARGIN && val == `VAL_FIRST;
	assign first_w = op == `OP_WATCHDOG && val == `VAL_FIRST;

	// Next values of interpreter, margins and timer.
	always_comb begin
		next_state = state;
		next_ldo   = ldo_margin_o;
		next_sw    = switcher_margin_o;
		next_on    = supervisor_timer_on_o;
		next_win   = supervisor_window_mode_o;
		next_sel   = supervisor_period_sel_o;
		next_cnt   = wd_cnt;
		next_exp   = 1'b0;
		// Free-running count; expiry restarts the period.
		if (supervisor_timer_on_o) begin
			if (wd_cnt >= 32'(period_of(supervisor_period_sel_o) - 32'h1))
			begin
				next_cnt = 32'h0;
				next_exp = 1'b1;
			end else
				next_cnt = 32'(wd_cnt + 32'h1);
		end
		if (link.stop_seen)
			next_state = CMD_IDLE;
		else if (link.byte_valid) begin
			case (state)
				CMD_IDLE: begin
					// Nothing executes without its first command.
					if (first_m)
						next_state = CMD_MARGIN;
					else if (first_w)
						next_state = CMD_WATCHDOG;
				end
				CMD_MARGIN: begin
					// Stays armed so both outputs can follow.
					if (op == `OP_MARGIN && val[3:0] != `MARGIN_BAD) begin
						if (val[`TARGET_POS])
							next_sw = val[3:0];
						else
							next_ldo = val[3:0];
					end else if (first_w)
						next_state = CMD_WATCHDOG;
				end
				CMD_WATCHDOG: begin
					if (first_w) begin
						next_on    = 1'b0;
						next_cnt   = 32'h0;
						next_state = CMD_IDLE;
					end else if (op == `OP_WATCHDOG
					             && val[4:3] == `WD_CODE_HI) begin
						// A refresh in a closed window is dropped.
						if (!supervisor_timer_on_o
						    || supervisor_window_open_o) begin
							next_on  = 1'b1;
							next_win = val[`WD_WIN_POS];
							next_sel = val[1:0];
							next_cnt = 32'h0;
							next_exp = 1'b0;
						end
						next_state = CMD_IDLE;
					end else if (first_m)
						next_state = CMD_MARGIN;
				end
				default: next_state = CMD_IDLE;
			endcase
		end
		// Window opens for the second half of the period.
		next_open = !next_win
		            || next_cnt >= (period_of(next_sel) >> 1);
	end

	// Interpreter, margin and timer registers.
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state                    <= CMD_IDLE;
			ldo_margin_o             <= `MARGIN_RESET;
			switcher_margin_o        <= `MARGIN_RESET;
			supervisor_timer_on_o    <= 1'b0;
			supervisor_window_mode_o <= 1'b0;
			supervisor_period_sel_o  <= `WD_SEL_RESET;
			supervisor_window_open_o <= 1'b1;
			supervisor_expired_o     <= 1'b0;
			wd_cnt                   <= 32'h0;
		end else begin
			state                    <= next_state;
			ldo_margin_o             <= next_ldo;
			switcher_margin_o        <= next_sw;
			supervisor_timer_on_o    <= next_on;
			supervisor_window_mode_o <= next_win;
			supervisor_period_sel_o  <= next_sel;
			supervisor_window_open_o <= next_open;
			supervisor_expired_o     <= next_exp;
			wd_cnt                   <= next_cnt;
		end
	end

	// =================================================================
	// Checks.
	sequence s_byte(logic [7:0] d);
		link.byte_valid && !link.stop_seen && link.cmd_byte == d;
	endsequence
	sequence s_armed(cmd_state_t s);
		state == s;
	endsequence

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	a_ldo_plus_five: assert property (s_armed(CMD_MARGIN) ##0
		s_byte(8'h25) |=> ldo_margin_o == 4'h5)
		else $error("Linear margin not set to plus five.");
	a_switch_minus_five: assert property (s_armed(CMD_MARGIN) ##0
		s_byte(8'h3c) |=> switcher_margin_o == 4'hc
		&& $stable(ldo_margin_o))
		else $error("Switcher margin not set to minus five.");
	a_first_cmd_needed: assert property (s_armed(CMD_IDLE) ##0
		link.byte_valid && op == `OP_MARGIN |=> $stable(ldo_margin_o)
		&& $stable(switcher_margin_o))
		else $error("Margin changed without a first command.");
	a_undefined_ignored: assert property (link.byte_valid
		&& op != `OP_MARGIN && op != `OP_WATCHDOG |=> $stable(ldo_margin_o)
		&& $stable(switcher_margin_o) && $stable(supervisor_period_sel_o))
		else $error("Undefined command changed state.");
	a_timer_start: assert property (s_armed(CMD_WATCHDOG) ##0
		s_byte(8'h6b) ##0 !supervisor_timer_on_o |=> supervisor_timer_on_o
		&& supervisor_period_sel_o == 2'h3 && wd_cnt == 32'h0)
		else $error("Timer did not start on programming byte.");
	a_open_refresh: assert property (s_armed(CMD_WATCHDOG) ##0
		s_byte(8'h6f) ##0 supervisor_window_open_o |=> wd_cnt == 32'h0
		&& supervisor_window_mode_o && supervisor_period_sel_o == 2'h3)
		else $error("Refresh in open window did not reload.");
	a_double_first_off: assert property (s_armed(CMD_WATCHDOG) ##0
		s_byte(8'h60) |=> !supervisor_timer_on_o ##1 !supervisor_timer_on_o)
		else $error("Timer still running after double first command.");
	a_stop_to_idle: assert property (link.stop_seen
		|=> state == CMD_IDLE)
		else $error("Pending first command survived STOP.");
	a_count_bound: assert property (supervisor_timer_on_o
		|-> wd_cnt < period_of(supervisor_period_sel_o))
		else $error("Timer count beyond its period.");

endmodule

// ### test/i2c_master_model.sv
/*
 * Bus master model: START, STOP and byte writes on an open-drain line.
 * Assumes the bench resolves the data line with a pull-up.
 */
module i2c_master_model (
	// Clock and resolved data line
	input  wire logic core_clk_i,
	input  wire logic sda_i,
	// Bus drive, high means released
	output logic      scl_o,
	output logic      sda_drv_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// =================================================================
	// Bus sequences
	// Both lines idle released until the first transfer.
	initial begin
		scl_o = 1'b1;
		sda_drv_o = 1'b1;
	end

	// Lets n core edges pass, then steps just off the edge.
	task automatic gap(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	// Data falls while the clock is high, from any earlier state.
	task automatic start();
		sda_drv_o = 1'b1;
		gap(2);
		scl_o = 1'b1;
		gap(4);
		sda_drv_o = 1'b0;
		gap(4);
		scl_o = 1'b0;
		gap(2);
	endtask

	// Only the master ends a transfer, data rising under a high clock.
	task automatic stop();
		sda_drv_o = 1'b0;
		gap(2);
		scl_o = 1'b1;
		gap(4);
		sda_drv_o = 1'b1;
		gap(4);
	endtask

	// One clock pulse; the line is read in the middle of the high phase.
	task automatic clk_bit(input logic b, output logic seen);
		sda_drv_o = b;
		gap(2);
		scl_o = 1'b1;
		gap(2);
		seen = sda_i;
		gap(2);
		scl_o = 1'b0;
		gap(2);
	endtask

	// Eight bits MSB first, then a released ninth bit for the ack.
	// The caller picks the direction bit inside the address byte.
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], s);
		end
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
endmodule

// ### test/i2c_margin_watchdog_cmd_bench.sv
/*
 * Self-checking bench of the margining and timer command block.
 * Assumes the master model and a pull-up on the data line.
 */
module i2c_margin_watchdog_cmd_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// =================================================================
	// Signals
	localparam int CPM = 8;
	logic       core_clk_i;
	logic       rst_b_i;
	logic       scl;
	logic       sda_drv;
	wire  logic sda;
	logic       sda_o;
	logic       sda_oe;
	logic [1:0] strap;
	logic [3:0] ldo;
	logic [3:0] sw;
	logic       tmr_on;
	logic       win_mode;
	logic [1:0] sel;
	logic       win_open;
	logic       expired;
	int         err_count;
	int         checks;

	// Pull-up: the line is low when either side pulls it.
	assign sda = sda_drv & ~sda_oe;

	// Core clock, 4 ns period.
	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// Straps give address 7'b1110110, write byte 8'hec.
	i2c_margin_watchdog_cmd #(.CYCLES_PER_MS(CPM)) dut_u (
		.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.upper_select_bit_i(strap[1]), .lower_select_bit_i(strap[0]),
		.ldo_margin_o(ldo), .switcher_margin_o(sw),
		.supervisor_timer_on_o(tmr_on),
		.supervisor_window_mode_o(win_mode),
		.supervisor_period_sel_o(sel),
		.supervisor_window_open_o(win_open),
		.supervisor_expired_o(expired)
	);

	i2c_master_model mst_u (
		.core_clk_i(core_clk_i), .sda_i(sda),
		.scl_o(scl), .sda_drv_o(sda_drv)
	);

	// =================================================================
	// Shared tasks
	// Compares one value and counts the outcome.
	task automatic chk(input string what, input logic [15:0] seen,
			input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Sends one byte and compares its ack with the expected one.
	task automatic wb(input logic [7:0] b, input logic exp);
		logic a;
		mst_u.put_byte(b, a);
		chk("ack", a, exp);
	endtask

	// Starts a transfer to the given address byte.
	task automatic go(input logic [7:0] adr, input logic exp);
		mst_u.start();
		wb(adr, exp);
	endtask

	// Timer command: first command, optional wait for the window, code.
	task automatic tmr(input logic [7:0] code, input logic hold);
		go(8'hec, 1'b1);
		wb(8'h60, 1'b1);
		if (hold) begin
			wait_for(1'b1);
		end
		wb(code, 1'b1);
		mst_u.stop();
	endtask

	// Bounded wait for the window (w=1) or an expiry pulse (w=0).
	int n;
	task automatic wait_for(input logic w);
		n = 0;
		while ((w ? win_open : expired) !== 1'b1) begin
			@(posedge core_clk_i);
			#1;
			n++;
			if (n > 12000) begin
				chk("wait", 16'h0, 16'h1);
				test_done();
			end
		end
	endtask

	// =================================================================
	// Scenarios
	// Two targets after one first command, then every code in one go.
	task automatic t_margin();
		go(8'hec, 1'b1);
		wb(8'h20, 1'b1);
		wb(8'h25, 1'b1);
		wb(8'h3c, 1'b1);
		mst_u.stop();
		chk("ldo", ldo, 16'h5);
		chk("sw", sw, 16'hc);
		go(8'hec, 1'b1);
		wb(8'h20, 1'b1);
		for (int c = 0; c < 15; c++) begin
			wb({4'h3, c[3:0]}, 1'b1);
			chk("sw code", sw, c[15:0]);
		end
		mst_u.stop();
		chk("ldo kept", ldo, 16'h5);
		$display("done margin");
	endtask

	// Arming lost at STOP, missing first command and undefined codes.
	task automatic t_guard();
		go(8'hec, 1'b1);
		wb(8'h20, 1'b1);
		mst_u.stop();
		go(8'hec, 1'b1);
		wb(8'h23, 1'b1);
		mst_u.stop();
		chk("ldo", ldo, 16'h5);
		go(8'hec, 1'b1);
		wb(8'h20, 1'b1);
		wb(8'h2f, 1'b1);
		wb(8'ha0, 1'b1);
		wb(8'h60, 1'b1);
		wb(8'h70, 1'b1);
		mst_u.stop();
		chk("ldo", ldo, 16'h5);
		chk("sw", sw, 16'he);
		chk("timer", tmr_on, 16'h0);
		$display("done guard");
	endtask

	// Read direction and a foreign address are neither acked nor obeyed.
	task automatic t_refuse();
		go(8'hed, 1'b0);
		wb(8'h20, 1'b0);
		wb(8'h21, 1'b0);
		mst_u.stop();
		go(8'hee, 1'b0);
		wb(8'h20, 1'b0);
		mst_u.stop();
		chk("ldo", ldo, 16'h5);
		chk("oe", sda_oe, 16'h0);
		chk("sda_o", sda_o, 16'h0);
		$display("done refuse");
	endtask

	// Start, period, every code, stop, restart and window refresh.
	task automatic t_timer();
		tmr(8'h6b, 1'b0);
		chk("on", tmr_on, 16'h1);
		wait_for(1'b0);
		@(posedge core_clk_i);
		#1;
		chk("pulse", expired, 16'h0);
		wait_for(1'b0);
		chk("period", 16'(n + 1), 16'(20 * CPM));
		for (int k = 0; k < 4; k++) begin
			tmr({6'h1a, k[1:0]}, 1'b0);
			chk("sel", sel, k[15:0]);
			chk("mode", win_mode, 16'h0);
		end
		tmr(8'h60, 1'b0);
		chk("off", tmr_on, 16'h0);
		tmr(8'h6c, 1'b0);
		chk("restart", tmr_on, 16'h1);
		tmr(8'h6f, 1'b0);
		chk("closed", sel, 16'h0);
		for (int k = 0; k < 4; k++) begin
			tmr({6'h1b, k[1:0]}, 1'b1);
			chk("sel", sel, k[15:0]);
			chk("mode", win_mode, 16'h1);
			chk("cleared", win_open, 16'h0);
		end
		$display("done timer");
	endtask

	// Mid-run reset with another strap pair moves the bus address.
	task automatic t_strap();
		strap = 2'h1;
		rst_b_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
		chk("ldo clr", ldo, 16'h0);
		chk("timer clr", tmr_on, 16'h0);
		rst_b_i = 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
		go(8'hec, 1'b0);
		mst_u.stop();
		go(8'hea, 1'b1);
		wb(8'h20, 1'b1);
		wb(8'h27, 1'b1);
		mst_u.stop();
		chk("ldo new", ldo, 16'h7);
		$display("done strap");
	endtask

	// =================================================================
	// Main sequence
	initial begin
		err_count = 0;
		checks = 0;
		strap = 2'h2;
		rst_b_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
		rst_b_i = 1'b1;
		repeat (3) @(posedge core_clk_i);
		#1;
		chk("ldo rst", ldo, 16'h0);
		chk("timer rst", tmr_on, 16'h0);
		t_margin();
		t_guard();
		t_refuse();
		t_timer();
		t_strap();
		test_done();
	end
endmodule
